// *** design/mspi_defs.vh ***
`ifndef MSPI_DEFS_VH
`define MSPI_DEFS_VH

// -----------------------------------------------------------------------------
// Clock and timing
// -----------------------------------------------------------------------------
`define MSPI_MCLK_NS 10
`define MSPI_MDC_HALF_NS 200
`define MSPI_MDC_HALF_CYC (`MSPI_MDC_HALF_NS / `MSPI_MCLK_NS)
`define MSPI_MDC_CNT_W 8

// -----------------------------------------------------------------------------
// Serial segment layout
// -----------------------------------------------------------------------------
`define MSPI_SEG_BITS 10
`define MSPI_SEG_ERR_BIT 0
`define MSPI_SEG_EN_BIT 1
`define MSPI_SEG_LAST_BIT 4'h9

// -----------------------------------------------------------------------------
// Management frame layout
// -----------------------------------------------------------------------------
`define MSPI_MG_PREAMBLE 7'h20
`define MSPI_MG_TA_BIT 7'h2E
`define MSPI_MG_DATA_BIT 7'h31
`define MSPI_MG_FRAME_END 7'h40
`define MSPI_MG_START 2'h1
`define MSPI_MG_OP_WR 2'h1
`define MSPI_MG_OP_RD 2'h2
`define MSPI_MG_TA_WR 2'h2
`define MSPI_MG_TA_RD 2'h3

// -----------------------------------------------------------------------------
// Synchroniser vector positions
// -----------------------------------------------------------------------------
`define MSPI_S_TXCLK 0
`define MSPI_S_RXCLK 1
`define MSPI_S_REFCLK 2
`define MSPI_S_STXCLK 3
`define MSPI_S_SRXCLK 4
`define MSPI_S_RXDV 5
`define MSPI_S_CRS 6
`define MSPI_S_COL 7
`define MSPI_S_MDC 8
`define MSPI_S_MDIO 9
`define MSPI_S_RXD 10
`define MSPI_S_N 14

`endif

// *** design/mspi_port.v ***
// Functional notes
// - MII transmit nibble changes on the PHY transmit clock rising edge.
// - Transmit enable rises with the first nibble, held until the frame ends.
// - MII receive nibble sampled on the PHY receive clock rising edge.
// - Serial transmit lane on nibble bit 0, timed by reference clock rise, or source transmit clock rise when source-synchronous.
// - Serial receive lane from nibble bit 0 on reference clock rise.
// - Source-synchronous serial receive captured on the dedicated receive clock.
// - Serial mode drives the upper three transmit lines low.
// - Serial mode ignores the upper three receive lines.
// - Management clock pin is an input after reset until configured to drive.
// - Management clock launches data out and samples data in.
// - Management data pin carries write data to every attached PHY.
// - Serial mode pulses segment sync once every ten link clocks.
`include "mspi_defs.vh"
`default_nettype none

// -----------------------------------------------------------------------------
// Transmit byte FIFO
// -----------------------------------------------------------------------------
module mspi_fifo #(
  parameter WIDTH = 9,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire mclk,
  input wire rst,
  input wire [WIDTH-1:0] in_data,
  input wire in_valid,
  output wire in_ready,
  output wire [WIDTH-1:0] out_data,
  output wire out_valid,
  input wire out_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0] cnt_q;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  assign in_ready = (cnt_q != DEPTH[AW:0]);
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign out_data = mem[rd_q];

  always @(posedge mclk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  always @(posedge mclk) begin
    if (rst) begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule

// -----------------------------------------------------------------------------
// Port interface top
// -----------------------------------------------------------------------------
module mspi_port #(
  parameter FIFO_DEPTH = 8,
  parameter MDC_HALF = `MSPI_MDC_HALF_CYC
) (
  input wire mclk,
  input wire rst,
  input wire mode_smii,
  input wire mode_src_sync,
  input wire [7:0] tx_data,
  input wire tx_last,
  input wire tx_valid,
  output wire tx_ready,
  output reg [7:0] rx_data_q,
  output reg rx_data_valid_q,
  output reg rx_frame_end_q,
  output wire carrier_sense,
  output wire collision,
  input wire port_tx_clock,
  output reg [3:0] port_tx_nibble_q,
  output reg port_tx_enable_q,
  input wire port_rx_clock,
  input wire [3:0] port_rx_nibble,
  input wire port_rx_valid,
  input wire port_carrier_sense,
  input wire port_collision,
  input wire serial_ref_clock,
  input wire serial_src_tx_clock,
  input wire serial_src_rx_clock,
  output reg serial_tx_segment_sync_q,
  input wire mgmt_clock_drive,
  input wire mgmt_start,
  input wire mgmt_read,
  input wire [4:0] mgmt_phy,
  input wire [4:0] mgmt_reg,
  input wire [15:0] mgmt_wdata,
  output reg mgmt_busy_q,
  output reg mgmt_done_q,
  output reg [15:0] mgmt_rdata_q,
  input wire mgmt_clock_pin_i,
  output reg mgmt_clock_pin_o_q,
  output wire mgmt_clock_pin_oe_n,
  input wire mgmt_data_pin_i,
  output reg mgmt_data_pin_o_q,
  output reg mgmt_data_pin_oe_n_q
);
  localparam ST_IDLE = 3'b001;
  localparam ST_LO = 3'b010;
  localparam ST_HI = 3'b100;

  // ---------------------------------------------------------------------------
  // Input synchronisers and edge detection
  // ---------------------------------------------------------------------------
  wire [`MSPI_S_N-1:0] async_in = {port_rx_nibble, mgmt_data_pin_i, mgmt_clock_pin_i,
    port_collision, port_carrier_sense, port_rx_valid, serial_src_rx_clock,
    serial_src_tx_clock, serial_ref_clock, port_rx_clock, port_tx_clock};
  reg [`MSPI_S_N-1:0] s1_q;
  reg [`MSPI_S_N-1:0] s2_q;
  reg [`MSPI_S_N-1:0] s3_q;
  wire [`MSPI_S_N-1:0] rise = s2_q & ~s3_q;
  wire [`MSPI_S_N-1:0] fall = ~s2_q & s3_q;
  genvar gi;
  generate
    for (gi = 0; gi < `MSPI_S_N; gi = gi + 1) begin : g_sync
      always @(posedge mclk) begin
        if (rst) begin
          s1_q[gi] <= 1'b0;
          s2_q[gi] <= 1'b0;
          s3_q[gi] <= 1'b0;
        end else begin
          s1_q[gi] <= async_in[gi];
          s2_q[gi] <= s1_q[gi];
          s3_q[gi] <= s2_q[gi];
        end
      end
    end
  endgenerate

  assign carrier_sense = s2_q[`MSPI_S_CRS];
  assign collision = s2_q[`MSPI_S_COL] && !mode_smii;

  // Link clocks are only visible through their sampled edges on mclk.
  wire ser_tx_edge = mode_src_sync ? rise[`MSPI_S_STXCLK] : rise[`MSPI_S_REFCLK];
  wire ser_rx_edge = mode_src_sync ? rise[`MSPI_S_SRXCLK] : rise[`MSPI_S_REFCLK];
  wire tx_edge = mode_smii ? ser_tx_edge : rise[`MSPI_S_TXCLK];
  wire rx_edge = mode_smii ? ser_rx_edge : rise[`MSPI_S_RXCLK];

  // ---------------------------------------------------------------------------
  // Transmit path
  // ---------------------------------------------------------------------------
  wire [8:0] f_data;
  wire f_valid;
  reg f_pop;
  mspi_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH), .AW(3)) u_fifo (
    .mclk(mclk),
    .rst(rst),
    .in_data({tx_last, tx_data}),
    .in_valid(tx_valid),
    .in_ready(tx_ready),
    .out_data(f_data),
    .out_valid(f_valid),
    .out_ready(f_pop)
  );

  reg [2:0] tx_st_q;
  reg [7:0] hold_q;
  reg hold_last_q;
  reg [3:0] tx_bit_q;
  reg [9:0] seg_q;
  wire mii_take = tx_edge && !mode_smii && (tx_st_q[0] || (tx_st_q[2] && !hold_last_q));
  wire ser_take = tx_edge && mode_smii && (tx_bit_q == 4'h0);

  always @* begin
    f_pop = f_valid && (mii_take || ser_take);
  end

  always @(posedge mclk) begin
    if (rst) begin
      tx_st_q <= ST_IDLE;
      hold_q <= 8'h00;
      hold_last_q <= 1'b0;
      tx_bit_q <= 4'h0;
      seg_q <= 10'h000;
      port_tx_nibble_q <= 4'h0;
      port_tx_enable_q <= 1'b0;
      serial_tx_segment_sync_q <= 1'b0;
    end else if (tx_edge && mode_smii) begin
      port_tx_enable_q <= 1'b0;
      tx_st_q <= ST_IDLE;
      if (tx_bit_q == 4'h0) begin
        seg_q <= {f_valid ? f_data[7:0] : 8'h00, f_valid, 1'b0};
        port_tx_nibble_q <= 4'h0;
        serial_tx_segment_sync_q <= 1'b1;
      end else begin
        port_tx_nibble_q <= {3'b000, seg_q[tx_bit_q]};
        serial_tx_segment_sync_q <= 1'b0;
      end
      tx_bit_q <= (tx_bit_q == `MSPI_SEG_LAST_BIT) ? 4'h0 : tx_bit_q + 4'h1;
    end else if (tx_edge) begin
      serial_tx_segment_sync_q <= 1'b0;
      tx_bit_q <= 4'h0;
      case (tx_st_q)
        ST_LO: begin
          port_tx_nibble_q <= hold_q[7:4];
          tx_st_q <= ST_HI;
        end
        default: begin
          if (mii_take && f_valid) begin
            hold_q <= f_data[7:0];
            hold_last_q <= f_data[8];
            port_tx_nibble_q <= f_data[3:0];
            port_tx_enable_q <= 1'b1;
            tx_st_q <= ST_LO;
          end else begin
            // An underrun mid-frame ends the frame; the PHY sees a short frame.
            port_tx_nibble_q <= 4'h0;
            port_tx_enable_q <= 1'b0;
            hold_last_q <= 1'b0;
            tx_st_q <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Receive path
  // ---------------------------------------------------------------------------
  reg have_lo_q;
  reg [3:0] lo_q;
  reg rx_act_q;
  reg [3:0] rx_bit_q;
  reg [9:0] rx_sh_q;
  wire [3:0] rx_nib = s2_q[`MSPI_S_RXD+3:`MSPI_S_RXD];
  wire rx_lane = s2_q[`MSPI_S_RXD];
  wire [9:0] rx_seg = {rx_lane, rx_sh_q[9:1]};

  always @(posedge mclk) begin
    if (rst) begin
      have_lo_q <= 1'b0;
      lo_q <= 4'h0;
      rx_act_q <= 1'b0;
      rx_bit_q <= 4'h0;
      rx_sh_q <= 10'h000;
      rx_data_q <= 8'h00;
      rx_data_valid_q <= 1'b0;
      rx_frame_end_q <= 1'b0;
    end else begin
      rx_data_valid_q <= 1'b0;
      rx_frame_end_q <= 1'b0;
      if (rx_edge && mode_smii) begin
        rx_sh_q <= rx_seg;
        rx_bit_q <= (rx_bit_q == `MSPI_SEG_LAST_BIT) ? 4'h0 : rx_bit_q + 4'h1;
        if (rx_bit_q == `MSPI_SEG_LAST_BIT) begin
          rx_act_q <= rx_seg[`MSPI_SEG_EN_BIT];
          rx_frame_end_q <= rx_act_q && !rx_seg[`MSPI_SEG_EN_BIT];
          if (rx_seg[`MSPI_SEG_EN_BIT]) begin
            rx_data_q <= rx_seg[9:2];
            rx_data_valid_q <= 1'b1;
          end
        end
      end else if (rx_edge) begin
        rx_bit_q <= 4'h0;
        rx_act_q <= s2_q[`MSPI_S_RXDV];
        rx_frame_end_q <= rx_act_q && !s2_q[`MSPI_S_RXDV];
        if (!s2_q[`MSPI_S_RXDV]) begin
          have_lo_q <= 1'b0;
        end else if (!have_lo_q) begin
          lo_q <= rx_nib;
          have_lo_q <= 1'b1;
        end else begin
          rx_data_q <= {rx_nib, lo_q};
          rx_data_valid_q <= 1'b1;
          have_lo_q <= 1'b0;
        end
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Management interface
  // ---------------------------------------------------------------------------
  reg drive_q;
  reg [`MSPI_MDC_CNT_W-1:0] div_q;
  reg [6:0] bitn_q;
  reg [31:0] mg_sh_q;
  reg mg_rd_q;
  wire own_tick = drive_q && (div_q == MDC_HALF[`MSPI_MDC_CNT_W-1:0] - 1'b1);
  wire mdc_rise = drive_q ? (own_tick && !mgmt_clock_pin_o_q) : rise[`MSPI_S_MDC];
  wire mdc_fall = drive_q ? (own_tick && mgmt_clock_pin_o_q) : fall[`MSPI_S_MDC];

  assign mgmt_clock_pin_oe_n = !drive_q;

  always @(posedge mclk) begin
    if (rst) begin
      drive_q <= 1'b0;
      div_q <= {`MSPI_MDC_CNT_W{1'b0}};
      mgmt_clock_pin_o_q <= 1'b0;
      bitn_q <= 7'h00;
      mg_sh_q <= 32'h00000000;
      mg_rd_q <= 1'b0;
      mgmt_busy_q <= 1'b0;
      mgmt_done_q <= 1'b0;
      mgmt_rdata_q <= 16'h0000;
      mgmt_data_pin_o_q <= 1'b1;
      mgmt_data_pin_oe_n_q <= 1'b1;
    end else begin
      drive_q <= mgmt_clock_drive;
      mgmt_done_q <= 1'b0;
      if (!drive_q || own_tick) begin
        div_q <= {`MSPI_MDC_CNT_W{1'b0}};
      end else begin
        div_q <= div_q + 1'b1;
      end
      if (own_tick) begin
        mgmt_clock_pin_o_q <= !mgmt_clock_pin_o_q;
      end
      if (!mgmt_busy_q && mgmt_start) begin
        mg_rd_q <= mgmt_read;
        mg_sh_q <= {`MSPI_MG_START, mgmt_read ? `MSPI_MG_OP_RD : `MSPI_MG_OP_WR, mgmt_phy,
          mgmt_reg, mgmt_read ? `MSPI_MG_TA_RD : `MSPI_MG_TA_WR, mgmt_wdata};
        bitn_q <= 7'h00;
        mgmt_busy_q <= 1'b1;
      end else if (mgmt_busy_q && mdc_fall && bitn_q != `MSPI_MG_FRAME_END) begin
        // A read releases the pin from the first turnaround bit on.
        mgmt_data_pin_oe_n_q <= mg_rd_q && (bitn_q >= `MSPI_MG_TA_BIT);
        if (bitn_q < `MSPI_MG_PREAMBLE) begin
          mgmt_data_pin_o_q <= 1'b1;
        end else begin
          mgmt_data_pin_o_q <= mg_sh_q[31];
          mg_sh_q <= {mg_sh_q[30:0], 1'b0};
        end
        bitn_q <= bitn_q + 7'h01;
      end else if (mgmt_busy_q && mdc_rise) begin
        if (mg_rd_q && bitn_q >= `MSPI_MG_DATA_BIT) begin
          mgmt_rdata_q <= {mgmt_rdata_q[14:0], s2_q[`MSPI_S_MDIO]};
        end
        if (bitn_q == `MSPI_MG_FRAME_END) begin
          mgmt_busy_q <= 1'b0;
          mgmt_done_q <= 1'b1;
          mgmt_data_pin_oe_n_q <= 1'b1;
          mgmt_data_pin_o_q <= 1'b1;
        end
      end
    end
  end
endmodule

`default_nettype wire

// *** verification/mspi_port_properties.sv ***
`default_nettype none

// --------------------
// Port timing checks
// --------------------
module mspi_port_properties #(
  parameter MDC_HALF = 20
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic mode_smii,
  input wire logic rx_data_valid_q,
  input wire logic port_tx_clock,
  input wire logic [3:0] port_tx_nibble_q,
  input wire logic port_tx_enable_q,
  input wire logic serial_ref_clock,
  input wire logic serial_tx_segment_sync_q,
  input wire logic mgmt_clock_drive,
  input wire logic mgmt_busy_q,
  input wire logic mgmt_done_q,
  input wire logic mgmt_clock_pin_o_q,
  input wire logic mgmt_clock_pin_oe_n,
  input wire logic mgmt_data_pin_o_q,
  input wire logic mgmt_data_pin_oe_n_q
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int DMIN = 124 * MDC_HALF;
  localparam int DMAX = 132 * MDC_HALF + 8;
  logic tq, rq, sq, bq, seen;
  logic [3:0] ta;
  logic [3:0] rc;
  logic [15:0] bc;
  // Edges are seen one cycle after the pin moves, the design needs two more to resynchronise.
  always @(posedge mclk) begin
    tq <= port_tx_clock;
    rq <= serial_ref_clock;
    sq <= serial_tx_segment_sync_q;
    bq <= mgmt_busy_q;
    if (mgmt_busy_q)
      bc <= bq ? bc + 16'h1 : 16'h1;
    if (rst) begin
      ta <= 4'hF;
      rc <= 4'h0;
      seen <= 1'b0;
    end else begin
      if (port_tx_clock && !tq)
        ta <= 4'h0;
      else if (ta != 4'hF)
        ta <= ta + 4'h1;
      if (serial_tx_segment_sync_q && !sq) begin
        rc <= 4'h0;
        seen <= 1'b1;
      end else if (serial_ref_clock && !rq && rc != 4'hF)
        rc <= rc + 4'h1;
    end
  end
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  upper_lines_zero_a: assert property (mode_smii |-> port_tx_nibble_q[3:1] == 3'h0)
    else $error("upper transmit lines moved in serial mode");
  serial_no_enable_a: assert property (mode_smii |-> !port_tx_enable_q)
    else $error("transmit enable high in serial mode");
  sync_period_a: assert property ($rose(serial_tx_segment_sync_q) && seen |-> rc == 4'hA)
    else $error("segment sync not ten link clocks apart");
  sync_width_a: assert property ($rose(serial_tx_segment_sync_q) |->
    serial_tx_segment_sync_q [*8] ##[1:12] !serial_tx_segment_sync_q)
    else $error("segment sync width wrong");
  nibble_timing_a: assert property (!mode_smii && $changed(port_tx_nibble_q) |-> ta <= 4'h6)
    else $error("nibble moved away from transmit clock rise");
  enable_timing_a: assert property (!mode_smii && $changed(port_tx_enable_q) |-> ta <= 4'h6)
    else $error("enable moved away from transmit clock rise");
  clock_input_a: assert property (!mgmt_clock_drive ##1 !mgmt_clock_drive |-> mgmt_clock_pin_oe_n)
    else $error("management clock driven without request");
  clock_output_a: assert property (mgmt_clock_drive ##1 mgmt_clock_drive |-> !mgmt_clock_pin_oe_n)
    else $error("management clock not driven");
  data_launch_a: assert property ($changed(mgmt_data_pin_o_q) && !mgmt_data_pin_oe_n_q &&
    !mgmt_clock_pin_oe_n |-> !mgmt_clock_pin_o_q)
    else $error("management data changed while clock high");
  frame_length_a: assert property (mgmt_done_q |-> bc >= DMIN && bc <= DMAX)
    else $error("management frame length wrong");
  rx_pulse_a: assert property (rx_data_valid_q |=> !rx_data_valid_q [*8])
    else $error("received bytes too close");
endmodule

bind mspi_port mspi_port_properties #(.MDC_HALF(MDC_HALF)) u_mspi_port_properties (
  .mclk(mclk), .rst(rst), .mode_smii(mode_smii), .rx_data_valid_q(rx_data_valid_q),
  .port_tx_clock(port_tx_clock), .port_tx_nibble_q(port_tx_nibble_q),
  .port_tx_enable_q(port_tx_enable_q), .serial_ref_clock(serial_ref_clock),
  .serial_tx_segment_sync_q(serial_tx_segment_sync_q), .mgmt_clock_drive(mgmt_clock_drive),
  .mgmt_busy_q(mgmt_busy_q), .mgmt_done_q(mgmt_done_q),
  .mgmt_clock_pin_o_q(mgmt_clock_pin_o_q), .mgmt_clock_pin_oe_n(mgmt_clock_pin_oe_n),
  .mgmt_data_pin_o_q(mgmt_data_pin_o_q), .mgmt_data_pin_oe_n_q(mgmt_data_pin_oe_n_q)
);

`default_nettype wire

// *** verification/mspi_phy_model.sv ***
`default_nettype none

// --------------------
// Far side of the link
// --------------------
module mspi_phy_model (
  input wire logic run,
  input wire logic [3:0] port_tx_nibble_q,
  input wire logic port_tx_enable_q,
  output var logic port_tx_clock,
  output var logic port_rx_clock,
  output var logic serial_ref_clock,
  output var logic [3:0] port_rx_nibble,
  output var logic port_rx_valid,
  output wire logic port_carrier_sense,
  output wire logic port_collision
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] got[$];
  // Clocks stop while run is low, which lets the bench stall the link with bytes queued.
  initial begin
    port_tx_clock = 1'b0;
    port_rx_clock = 1'b0;
    port_rx_nibble = 4'hA;
    port_rx_valid = 1'b0;
    #3;
    forever begin
      #80;
      if (run) begin
        port_tx_clock = ~port_tx_clock;
        port_rx_clock = ~port_rx_clock;
      end
    end
  end
  initial begin
    serial_ref_clock = 1'b0;
    #41;
    forever begin
      #80;
      if (run)
        serial_ref_clock = ~serial_ref_clock;
    end
  end
  assign port_carrier_sense = port_tx_enable_q | port_rx_valid;
  assign port_collision = 1'b0;
  always @(posedge port_tx_clock)
    if (port_tx_enable_q === 1'b1)
      got.push_back(port_tx_nibble_q);
  // Nibbles change on the falling edge so they are steady at the sampling rise.
  task automatic rx_frame(input logic [15:0] w);
    for (int i = 0; i < 4; i++) begin
      @(negedge port_rx_clock);
      port_rx_valid = 1'b1;
      port_rx_nibble = w[4*i +: 4];
    end
    @(negedge port_rx_clock);
    port_rx_valid = 1'b0;
    port_rx_nibble = ~port_rx_nibble;
  endtask
endmodule

`default_nettype wire

// *** verification/mspi_port_test.sv ***
`default_nettype none

// --------------------
// Port interface bench
// --------------------
module mspi_port_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic mode_smii = 1'b0;
  logic run = 1'b0;
  logic [7:0] tx_data = 8'h00;
  logic tx_last = 1'b0;
  logic tx_valid = 1'b0;
  logic drive = 1'b0;
  logic start = 1'b0;
  logic mread = 1'b0;
  logic [4:0] mphy = 5'h00;
  logic [4:0] mreg = 5'h00;
  logic [15:0] wdata = 16'h0000;
  wire tx_ready, rxv_q, sync, busy, done, tx_en, ck_o, ck_oe_n, d_o, d_oe_n;
  wire txc, rxc, refc, rxv, crs, col, fe, cs, cl;
  int n_end = 0;
  wire [7:0] rx_q;
  wire [3:0] nib;
  wire [3:0] rxn;
  // Data pin has a pull-up; a released clock pin shows the inverse of its last level.
  wire ck_i = ck_o ^ ck_oe_n;
  wire d_i = d_oe_n | d_o;
  int mismatches = 0;
  int n_compared = 0;
  logic [7:0] rxq[$];
  logic mq;
  logic [63:0] mf;
  mspi_port #(.MDC_HALF(2)) u_mspi_port (
    .mclk(mclk), .rst(rst), .mode_smii(mode_smii), .mode_src_sync(1'b0),
    .tx_data(tx_data), .tx_last(tx_last), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .rx_data_q(rx_q), .rx_data_valid_q(rxv_q), .rx_frame_end_q(fe), .carrier_sense(cs),
    .collision(cl), .port_tx_clock(txc), .port_tx_nibble_q(nib), .port_tx_enable_q(tx_en),
    .port_rx_clock(rxc), .port_rx_nibble(rxn), .port_rx_valid(rxv),
    .port_carrier_sense(crs), .port_collision(col), .serial_ref_clock(refc),
    .serial_src_tx_clock(1'b0), .serial_src_rx_clock(1'b0),
    .serial_tx_segment_sync_q(sync), .mgmt_clock_drive(drive), .mgmt_start(start),
    .mgmt_read(mread), .mgmt_phy(mphy), .mgmt_reg(mreg), .mgmt_wdata(wdata),
    .mgmt_busy_q(busy), .mgmt_done_q(done), .mgmt_rdata_q(), .mgmt_clock_pin_i(ck_i),
    .mgmt_clock_pin_o_q(ck_o), .mgmt_clock_pin_oe_n(ck_oe_n), .mgmt_data_pin_i(d_i),
    .mgmt_data_pin_o_q(d_o), .mgmt_data_pin_oe_n_q(d_oe_n)
  );
  mspi_phy_model u_mspi_phy_model (
    .run(run), .port_tx_nibble_q(nib), .port_tx_enable_q(tx_en), .port_tx_clock(txc),
    .port_rx_clock(rxc), .serial_ref_clock(refc), .port_rx_nibble(rxn),
    .port_rx_valid(rxv), .port_carrier_sense(crs), .port_collision(col)
  );
  always #5 mclk = ~mclk;
  always @(posedge mclk) begin
    mq <= ck_o;
    if (ck_o && !mq && (busy || done))
      mf <= {mf[62:0], d_i};
    if (rxv_q === 1'b1)
      rxq.push_back(rx_q);
    if (fe === 1'b1)
      n_end <= n_end + 1;
  end
  task automatic check(input string what, input logic [63:0] exp, input logic [63:0] seen);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic give_up;
    mismatches++;
    test_done;
  endtask
  task automatic step;
    @(posedge mclk);
    #1;
  endtask
  task automatic t_reset;
    rst = 1'b1;
    repeat (8) step;
    rst = 1'b0;
    step;
    check("clock pin oe_n", 1, ck_oe_n);
    check("data pin oe_n", 1, d_oe_n);
    check("tx enable", 0, tx_en);
    check("tx ready", 1, tx_ready);
  endtask
  // The link is stalled while the queue fills, so nothing drains early.
  task automatic t_fill_drain;
    int n;
    n = 0;
    while (n < 12 && tx_ready === 1'b1) begin
      tx_data = 8'h10 | n[7:0];
      tx_last = (n == 7);
      tx_valid = 1'b1;
      step;
      n++;
    end
    tx_valid = 1'b0;
    tx_last = 1'b0;
    check("queue depth", 8, n);
    run = 1'b1;
    for (n = 0; n < 3000 && u_mspi_phy_model.got.size() < 16; n++)
      step;
    if (n == 3000)
      give_up;
    repeat (80) step;
    check("nibble count", 16, u_mspi_phy_model.got.size());
    check("tx enable idle", 0, tx_en);
    for (n = 0; n < 16; n++)
      check("tx nibble", (n % 2) ? 1 : n / 2, u_mspi_phy_model.got[n]);
  endtask
  task automatic t_rx;
    u_mspi_phy_model.rx_frame(16'h813C);
    repeat (40) step;
    check("rx count", 2, rxq.size());
    check("rx byte 0", 8'h3C, rxq[0]);
    check("rx byte 1", 8'h81, rxq[1]);
    check("rx frame end", 1, n_end);
    check("carrier sense", 0, cs);
    check("collision", 0, cl);
  endtask
  task automatic t_mgmt;
    int n;
    drive = 1'b1;
    repeat (2) step;
    mphy = 5'h11;
    mreg = 5'h0A;
    wdata = 16'hBEEF;
    start = 1'b1;
    step;
    start = 1'b0;
    for (n = 0; n < 1000 && done !== 1'b1; n++)
      step;
    if (n == 1000)
      give_up;
    repeat (4) step;
    check("mgmt frame", {32'hFFFFFFFF, 2'h1, 2'h1, 5'h11, 5'h0A, 2'h2, 16'hBEEF}, mf);
    // Hand the clock pin back so a later reset finds it released.
    drive = 1'b0;
    repeat (2) step;
    check("clock pin released", 1, ck_oe_n);
  endtask
  task automatic t_smii;
    int k;
    int n;
    logic [9:0] seg;
    mode_smii = 1'b1;
    t_reset;
    tx_data = 8'hA5;
    tx_last = 1'b1;
    tx_valid = 1'b1;
    step;
    tx_valid = 1'b0;
    n = 20;
    seg = 10'h000;
    for (k = 0; k < 80 && !(n == 10 && seg[1] === 1'b1); k++) begin
      @(negedge refc);
      if (sync === 1'b1)
        n = 0;
      seg = {nib[0], seg[9:1]};
      n++;
    end
    check("serial segment", 10'h296, seg);
  endtask
  initial begin
    t_reset;
    t_fill_drain;
    t_rx;
    t_mgmt;
    t_smii;
    test_done;
  end
endmodule

`default_nettype wire
